// >>> pmac_core.sv
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module pmac_core
  import pmac_pkg::*;
#(
  parameter int FIRST_CYCLES = FIRST_CYC,
  parameter int SLOW_CYCLES  = SLOW_CYC,
  parameter int FAST_CYCLES  = FAST_CYC
) (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              srst,
  // Register port.
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  // Wake-up sources and converter sample, all from outside the clock domain.
  input  wire logic [1:0]        wake_n,
  input  wire logic              alarm,
  input  wire logic [DATA_W-1:0] adc_sample,
  // Power and converter controls.
  output pmac_pwr_t              pwr_en,
  output logic                   ext_supply_shutdown_out,
  output logic                   pll_clock_output,
  output logic                   pos_input_buffer_enable,
  output logic                   neg_input_buffer_enable,
  output logic                   bipolar_select,
  output logic      [1:0]        gain_sel,
  output logic      [7:0]        chan_sel,
  output logic                   data_ready,
  // DAC codes.
  output logic      [DAC_W-1:0]  first_force_dac,
  output logic      [DAC_W-1:0]  second_force_dac
);

  // ---------------------------------------------------------------------------
  // Parameter checks.
  // ---------------------------------------------------------------------------
  if (FIRST_CYCLES < 2 || FIRST_CYCLES >= (1 << CNT_W)) begin : g_chk_first
    $error("FIRST_CYCLES out of range");
  end
  if (SLOW_CYCLES < 2 || FAST_CYCLES < 2 || SLOW_CYCLES >= (1 << CNT_W)) begin : g_chk_rate
    $error("rate period out of range");
  end

  typedef enum logic [1:0] {ADC_OFF, ADC_CONV, ADC_CAL} pmac_adc_st_t;

  // ---------------------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------------------
  pmac_mode_t          mode_q;            // Current power mode.
  pmac_pwr_t           pwr_q;             // Block power enables.
  pmac_adc_st_t        adc_st_q;          // Converter sequencer.
  logic [CNT_W-1:0]    cnt_q;             // Cycles left to the next result.
  logic [7:0]          ctrl_q;            // ADC control register.
  logic [7:0]          chan_q;            // Channel select register.
  logic [DATA_W-1:0]   offset_q;          // Offset, two's complement.
  logic [DATA_W-1:0]   data_q;            // Last corrected result.
  logic [DAC_W-1:0]    dac_a_q;           // First DAC code.
  logic [DAC_W-1:0]    dac_b_q;           // Second DAC code.
  logic [DATA_W-1:0]   rdata_q;           // Read data, one cycle after strobe.
  logic                drdy_q;            // Result written pulse.
  logic                clkout_q;          // Clock output level.
  logic [6:0]          fdiv_q;            // Clock output divider.
  logic [1:0]          wake_m_q;          // First synchroniser stage.
  logic [1:0]          wake_s_q;          // Synchronised wake lines.
  logic [1:0]          wake_d_q;          // Delayed for edge detect.
  logic                alarm_m_q;         // First synchroniser stage.
  logic                alarm_s_q;         // Synchronised alarm.
  logic                alarm_d_q;         // Delayed for edge detect.
  logic [DATA_W-1:0]   samp_m_q;          // First synchroniser stage.
  logic [DATA_W-1:0]   samp_s_q;          // Synchronised sample.

  // ---------------------------------------------------------------------------
  // Decoding.
  // ---------------------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [4:0] r);
    hit = (a == r);
  endfunction

  function automatic logic [CNT_W-1:0] period(input logic fast);
    period = fast ? CNT_W'(FAST_CYCLES - 1) : CNT_W'(SLOW_CYCLES - 1);
  endfunction

  wire                 wr_sleep   = wr && hit(addr, ADR_CMD_SLEEP);
  wire                 wr_standby = wr && hit(addr, ADR_CMD_STANDBY);
  wire                 wr_idle    = wr && hit(addr, ADR_CMD_IDLE);
  wire                 wr_run     = wr && hit(addr, ADR_CMD_RUN);
  wire                 wr_mode    = wr_sleep || wr_standby || wr_idle || wr_run;
  wire                 wr_ctrl    = wr && hit(addr, ADR_ADC_CTRL);
  wire                 wr_offset  = wr && hit(addr, ADR_OFFSET);
  // A falling wake line or a rising alarm is one wake-up event.
  wire                 wake_evt   = |(wake_d_q & ~wake_s_q) || (alarm_s_q && !alarm_d_q);
  wire                 adc_on     = pwr_q.adc;
  wire                 cnt_done   = (cnt_q == '0);
  wire                 conv_done  = (adc_st_q == ADC_CONV) && cnt_done;
  wire                 cal_done   = (adc_st_q == ADC_CAL) && cnt_done;
  // A start write arms the sequencer; the calibration bit picks the kind.
  wire                 start_req  = wr_ctrl && wdata[CTL_START];
  wire [DATA_W-1:0]    corrected  = samp_s_q - offset_q;

  // ---------------------------------------------------------------------------
  // Input synchronisers.
  // ---------------------------------------------------------------------------
  // Each outside level passes two flops before any logic reads it.
  always_ff @(posedge clk) begin
    wake_m_q  <= wake_n;
    wake_s_q  <= wake_m_q;
    wake_d_q  <= wake_s_q;
    alarm_m_q <= alarm;
    alarm_s_q <= alarm_m_q;
    alarm_d_q <= alarm_s_q;
    samp_m_q  <= adc_sample;
    samp_s_q  <= samp_m_q;
  end

  // ---------------------------------------------------------------------------
  // Power mode and block enables.
  // ---------------------------------------------------------------------------
  // A mode command sets the whole map; a later command in the same cycle as
  // a wake-up wins, since it is the newer instruction.
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q <= MODE_STANDBY;
      pwr_q  <= PWR_STANDBY;
    end else if (wr_mode) begin
      if (wr_sleep) begin
        mode_q <= MODE_SLEEP;
        pwr_q  <= PWR_SLEEP;
      end else if (wr_standby) begin
        mode_q <= MODE_STANDBY;
        pwr_q  <= PWR_STANDBY;
      end else if (wr_idle) begin
        mode_q <= MODE_IDLE;
        pwr_q  <= PWR_IDLE;
      end else begin
        mode_q <= MODE_RUN;
        pwr_q  <= PWR_RUN;
      end
    end else if (wake_evt) begin
      // Support blocks come up; converter-side enables keep their state.
      pwr_q <= pwr_q | PWR_WAKE_SET;
      if (mode_q == MODE_SLEEP) begin
        mode_q <= MODE_STANDBY;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Host registers.
  // ---------------------------------------------------------------------------
  // Control register: hardware clears start and calibrate after a
  // calibration, but a host write in that cycle is newer and wins.
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= ADC_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= wdata[7:0];
    end else if (cal_done) begin
      ctrl_q[CTL_CAL]   <= 1'b0;
      ctrl_q[CTL_START] <= 1'b0;
    end
  end

  // Channel select and DAC codes are plain host-written registers.
  always_ff @(posedge clk) begin
    if (srst) begin
      chan_q  <= CHAN_SEL_RST;
      dac_a_q <= '0;
      dac_b_q <= '0;
    end else if (wr) begin
      if (hit(addr, ADR_CHAN_SEL)) begin
        chan_q <= wdata[7:0];
      end
      if (hit(addr, ADR_DAC_A)) begin
        dac_a_q <= wdata[DAC_W-1:0];
      end
      if (hit(addr, ADR_DAC_B)) begin
        dac_b_q <= wdata[DAC_W-1:0];
      end
    end
  end

  // Offset register: loaded by a calibration or by the host.
  always_ff @(posedge clk) begin
    if (srst) begin
      offset_q <= '0;
    end else if (cal_done) begin
      offset_q <= samp_s_q;
    end else if (wr_offset) begin
      offset_q <= wdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Converter sequencer.
  // ---------------------------------------------------------------------------
  // The first result waits the settling time; later results follow at the
  // selected rate without another start. Power-down stops everything.
  always_ff @(posedge clk) begin
    if (srst) begin
      adc_st_q <= ADC_OFF;
      cnt_q    <= '0;
    end else if (!adc_on) begin
      adc_st_q <= ADC_OFF;
      cnt_q    <= '0;
    end else if (start_req) begin
      adc_st_q <= wdata[CTL_CAL] ? ADC_CAL : ADC_CONV;
      cnt_q    <= CNT_W'(FIRST_CYCLES - 1);
    end else begin
      case (adc_st_q)
        ADC_CONV: begin
          cnt_q <= cnt_done ? period(ctrl_q[CTL_RATE]) : cnt_q - 1'b1;
        end
        ADC_CAL: begin
          if (cnt_done) begin
            adc_st_q <= ADC_OFF;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: begin
          cnt_q <= '0;
        end
      endcase
    end
  end

  // Result register with the offset removed, and its ready pulse.
  always_ff @(posedge clk) begin
    if (srst) begin
      data_q <= '0;
      drdy_q <= 1'b0;
    end else begin
      drdy_q <= conv_done && adc_on;
      if (conv_done && adc_on) begin
        data_q <= corrected;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Clock output divider, running only while enabled.
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst || !pwr_q.clk_out) begin
      fdiv_q   <= '0;
      clkout_q <= 1'b0;
    end else if (fdiv_q == 7'(CLKOUT_HALF_CYC - 1)) begin
      fdiv_q   <= '0;
      clkout_q <= !clkout_q;
    end else begin
      fdiv_q <= fdiv_q + 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Read path.
  // ---------------------------------------------------------------------------
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    case (addr)
      ADR_ADC_CTRL: rd_mux = {8'h00, ctrl_q};
      ADR_CHAN_SEL: rd_mux = {8'h00, chan_q};
      ADR_OFFSET:   rd_mux = offset_q;
      ADR_DATA:     rd_mux = data_q;
      ADR_DAC_A:    rd_mux = {6'h00, dac_a_q};
      ADR_DAC_B:    rd_mux = {6'h00, dac_b_q};
      ADR_STATUS:   rd_mux = {10'h000, adc_st_q, 2'h0, mode_q};
      default:      rd_mux = '0;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rd ? rd_mux : '0;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs, each straight from a flop.
  // ---------------------------------------------------------------------------
  assign rdata                   = rdata_q;
  assign pwr_en                  = pwr_q;
  assign ext_supply_shutdown_out = pwr_q.supply_hi;
  assign pll_clock_output        = clkout_q;
  assign pos_input_buffer_enable = ctrl_q[CTL_POS_BUF];
  assign neg_input_buffer_enable = ctrl_q[CTL_NEG_BUF];
  assign bipolar_select          = ctrl_q[CTL_BIPOLAR];
  assign gain_sel                = ctrl_q[CTL_GAIN_LO +: 2];
  assign chan_sel                = chan_q;
  assign data_ready              = drdy_q;
  assign first_force_dac         = dac_a_q;
  assign second_force_dac        = dac_b_q;

  // ---------------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  chk_sleep_map: assert property (wr_sleep |=> pwr_q == PWR_SLEEP && mode_q == MODE_SLEEP)
    else $error("sleep command did not set sleep power map");
  chk_run_map: assert property (wr_run |=> pwr_q == PWR_RUN && mode_q == MODE_RUN)
    else $error("run command did not reach run mode");
  chk_wake_keep: assert property (wake_evt && !wr_mode |=>
      pwr_q[7:0] == $past(pwr_q[7:0]) && pwr_q[12:8] == 5'h1f)
    else $error("wake-up changed converter power or missed support blocks");
  chk_reset_dflt: assert property (disable iff (1'b0) srst |=>
      ctrl_q == ADC_CTRL_RST && mode_q == MODE_STANDBY && !pos_input_buffer_enable)
    else $error("reset defaults wrong");
  chk_first_wait: assert property (start_req && adc_on |=>
      cnt_q == CNT_W'(FIRST_CYCLES - 1) && adc_st_q != ADC_OFF)
    else $error("start did not load first-result wait");
  chk_keep_conv: assert property (conv_done && adc_on && !wr_ctrl |=>
      adc_st_q == ADC_CONV && cnt_q == $past(period(ctrl_q[CTL_RATE])) && data_ready)
    else $error("conversion did not continue");
  chk_cal_once: assert property (cal_done && adc_on && !wr_ctrl |=>
      adc_st_q == ADC_OFF && !ctrl_q[CTL_CAL] && !ctrl_q[CTL_START] ##1 !data_ready)
    else $error("calibration did not stop and clear");
  chk_cal_store: assert property (cal_done && adc_on |=> offset_q == $past(samp_s_q))
    else $error("calibration result not stored");
  chk_sub_offset: assert property (conv_done && adc_on |=>
      data_q == DATA_W'($past(samp_s_q) - $past(offset_q)))
    else $error("result not offset-corrected");
  chk_host_offset: assert property (wr_offset && !cal_done |=> offset_q == $past(wdata))
    else $error("host offset write lost");
  chk_dac_code: assert property (wr && hit(addr, ADR_DAC_A) |=>
      first_force_dac == $past(wdata[DAC_W-1:0]))
    else $error("DAC code not taken");

  cov_conv: cover property (start_req && adc_on ##[1:1000] conv_done);
  cov_cal: cover property (cal_done);
  cov_wake: cover property (mode_q == MODE_SLEEP && wake_evt);

endmodule // pmac_core

// >>> pmac_pkg.sv
package pmac_pkg;

  // ---------------------------------------------------------------------------
  // Register port geometry.
  // ---------------------------------------------------------------------------
  localparam int          ADDR_W          = 5;
  localparam int          DATA_W          = 16;
  localparam int          DAC_W           = 10;

  // ---------------------------------------------------------------------------
  // Register addresses; the four mode commands carry no data.
  // ---------------------------------------------------------------------------
  localparam logic [4:0]  ADR_ADC_CTRL    = 5'h01;
  localparam logic [4:0]  ADR_CHAN_SEL    = 5'h02;
  localparam logic [4:0]  ADR_OFFSET      = 5'h03;
  localparam logic [4:0]  ADR_DATA        = 5'h04;
  localparam logic [4:0]  ADR_DAC_A       = 5'h05;
  localparam logic [4:0]  ADR_DAC_B       = 5'h06;
  localparam logic [4:0]  ADR_STATUS      = 5'h07;
  localparam logic [4:0]  ADR_CMD_SLEEP   = 5'h1a;
  localparam logic [4:0]  ADR_CMD_STANDBY = 5'h1b;
  localparam logic [4:0]  ADR_CMD_IDLE    = 5'h1c;
  localparam logic [4:0]  ADR_CMD_RUN     = 5'h1d;

  // ---------------------------------------------------------------------------
  // ADC control field positions and reset values.
  // ---------------------------------------------------------------------------
  localparam int          CTL_START       = 0;
  localparam int          CTL_CAL         = 1;
  localparam int          CTL_RATE        = 2;
  localparam int          CTL_GAIN_LO     = 3;
  localparam int          CTL_POS_BUF     = 5;
  localparam int          CTL_NEG_BUF     = 6;
  localparam int          CTL_BIPOLAR     = 7;
  localparam logic [7:0]  ADC_CTRL_RST    = 8'h00;
  localparam logic [7:0]  CHAN_SEL_RST    = 8'h00;

  // ---------------------------------------------------------------------------
  // Conversion and clock output timing.
  // ---------------------------------------------------------------------------
  localparam int          CLK_HZ          = 200_000_000;
  localparam int          FIRST_RESULT_MS = 100;
  localparam int          RATE_SLOW_HZ    = 30;
  localparam int          RATE_FAST_HZ    = 60;
  localparam int          FIRST_CYC       = FIRST_RESULT_MS * (CLK_HZ / 1000);
  localparam int          SLOW_CYC        = CLK_HZ / RATE_SLOW_HZ;
  localparam int          FAST_CYC        = CLK_HZ / RATE_FAST_HZ;
  localparam int          CNT_W           = 25;
  localparam int          CLKOUT_HALF_CYC = 41;

  // ---------------------------------------------------------------------------
  // Switchable power blocks; always-on blocks are not listed.
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic low_vdd_mon;
    logic bias;
    logic pll;
    logic clk_out;
    logic supply_hi;
    logic dac_a;
    logic dac_b;
    logic bandgap;
    logic bg_buf;
    logic sig_det;
    logic adc_mux;
    logic adc_buf;
    logic adc;
  } pmac_pwr_t;

  localparam pmac_pwr_t   PWR_SLEEP       = 13'h0000;
  localparam pmac_pwr_t   PWR_STANDBY     = 13'h1f00;
  localparam pmac_pwr_t   PWR_IDLE        = 13'h1ffc;
  localparam pmac_pwr_t   PWR_RUN         = 13'h1fff;
  localparam pmac_pwr_t   PWR_WAKE_SET    = 13'h1f00;

  typedef enum logic [1:0] {MODE_SLEEP, MODE_STANDBY, MODE_IDLE, MODE_RUN} pmac_mode_t;

endpackage

// >>> pmac_host.sv
`timescale 1ns/100ps
// -----------------------------------------------------------------------------
// Host side of the register port: one-cycle strobes, launched after a rising edge.
// -----------------------------------------------------------------------------
module pmac_host
  import pmac_pkg::*;
(
  // Clock and read data from the device.
  input  wire logic              clk,
  input  wire logic [DATA_W-1:0] rdata,
  // Request lines towards the device.
  output logic      [ADDR_W-1:0] addr,
  output logic      [DATA_W-1:0] wdata,
  output logic                   wr,
  output logic                   rd
);
  // Idle values from time zero so the device never sees an unknown strobe.
  initial begin
    addr  = '0;
    wdata = '0;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // A write holds address and data for exactly one strobe cycle.
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // A read takes the data in the cycle after the strobe, and only there.
  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
endmodule // pmac_host

// >>> power_mode_adc_control_test.sv
`timescale 1ns/100ps
module power_mode_adc_control_test;
  import pmac_pkg::*;
  // Shortened conversion counts; every conversion wait the test expects follows from these.
  localparam int FIRST_T = 40;
  localparam int SLOW_T  = 20;
  localparam int FAST_T  = 10;
  logic              clk = 1'b0;
  logic              srst;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, rv, smp, off;
  logic              wr, rd, alarm, shut_o, pll_o, pbuf_o, nbuf_o, bipol_o, drdy;
  logic [1:0]        wake_n, gain;
  logic [7:0]        chan;
  logic [DAC_W-1:0]  dac_a, dac_b, dv;
  pmac_pwr_t         pwr_en;
  int                miscompares = 0, total_checks = 0, cyc = 0, n;
  pmac_pwr_t         mode_pwr [4] = '{PWR_SLEEP, PWR_STANDBY, PWR_IDLE, PWR_RUN};
  logic [4:0]        mode_adr [4] = '{ADR_CMD_SLEEP, ADR_CMD_STANDBY, ADR_CMD_IDLE, ADR_CMD_RUN};

  // ---------------------------------------------------------------------------
  // Clock, hang guard and instances.
  // ---------------------------------------------------------------------------
  always #2.5 clk = ~clk;
  // A run far beyond the expected length counts as a failure.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  pmac_host host_u (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  pmac_core #(.FIRST_CYCLES(FIRST_T), .SLOW_CYCLES(SLOW_T), .FAST_CYCLES(FAST_T)) dut_u (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .wake_n(wake_n), .alarm(alarm), .adc_sample(smp), .pwr_en(pwr_en),
    .ext_supply_shutdown_out(shut_o), .pll_clock_output(pll_o),
    .pos_input_buffer_enable(pbuf_o), .neg_input_buffer_enable(nbuf_o),
    .bipolar_select(bipol_o), .gain_sel(gain), .chan_sel(chan), .data_ready(drdy),
    .first_force_dac(dac_a), .second_force_dac(dac_b));

  // ---------------------------------------------------------------------------
  // Helpers.
  // ---------------------------------------------------------------------------
  // Expected data register value: raw sample less the stored offset.
  function automatic logic [15:0] exp_data(input logic [15:0] s, input logic [15:0] o);
    return s - o;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Counts settled cycles until a result pulse, bounded.
  task automatic wait_ready(output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (drdy !== 1'b1 && k < 200);
  endtask
  // Counts settled cycles until the clock output shows a level, bounded.
  task automatic wait_clk_out(input logic lvl, output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (pll_o !== lvl && k < 200);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------------------
  initial begin
    srst = 1'b1;
    wake_n = 2'b11;
    alarm = 1'b0;
    smp = $urandom(32'h3ed0);
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    chk(16'(pwr_en), 16'(PWR_STANDBY));
    chk(16'({gain, pbuf_o, nbuf_o, bipol_o, shut_o}), 16'h0001);
    host_u.rd_reg(ADR_STATUS, rv);
    chk(16'(rv[1:0]), 16'h0001);
    // Every mode command, with random data that must be ignored.
    for (int i = 0; i < 4; i++) begin
      host_u.wr_reg(mode_adr[i], 16'($urandom));
      #1;
      chk(16'(pwr_en), 16'(mode_pwr[i]));
      chk(16'(shut_o), 16'(i != 0));
    end
    // Wake from sleep, then a wake in idle that must change nothing.
    host_u.wr_reg(ADR_CMD_SLEEP, 16'h0000);
    @(posedge clk) wake_n <= 2'b10;
    repeat (6) @(posedge clk);
    #1;
    chk(16'(pwr_en), 16'(PWR_WAKE_SET));
    // The clock output was held low in sleep and now runs at its half period.
    chk(16'(pll_o), 16'h0000);
    wait_clk_out(1'b1, n);
    wait_clk_out(1'b0, n);
    chk(16'(n), 16'(CLKOUT_HALF_CYC));
    @(posedge clk) wake_n <= 2'b11;
    host_u.wr_reg(ADR_CMD_IDLE, 16'h0000);
    @(posedge clk) alarm <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk(16'(pwr_en), 16'(PWR_IDLE));
    @(posedge clk) alarm <= 1'b0;
    // Conversion at both rates.
    host_u.wr_reg(ADR_CMD_RUN, 16'h0000);
    host_u.wr_reg(ADR_CHAN_SEL, 16'h0094);
    #1;
    chk(16'(chan), 16'h0094);
    for (int r = 0; r < 2; r++) begin
      @(posedge clk) smp <= 16'($urandom);
      host_u.wr_reg(ADR_ADC_CTRL, 16'(r * 4 + 1));
      wait_ready(n);
      chk(16'(n), 16'(FIRST_T));
      wait_ready(n);
      chk(16'(n), 16'(r ? FAST_T : SLOW_T));
      host_u.rd_reg(ADR_DATA, rv);
      chk(rv, exp_data(smp, 16'h0000));
    end
    // One calibration, then the offset is used on later results.
    @(posedge clk) smp <= 16'($urandom);
    host_u.wr_reg(ADR_ADC_CTRL, 16'h0003);
    off = smp;
    repeat (FIRST_T + 6) @(posedge clk);
    host_u.rd_reg(ADR_OFFSET, rv);
    chk(rv, off);
    host_u.rd_reg(ADR_ADC_CTRL, rv);
    chk(16'(rv[1:0]), 16'h0000);
    host_u.rd_reg(ADR_STATUS, rv);
    chk(16'(rv[5:4]), 16'h0000);
    for (int h = 0; h < 2; h++) begin
      if (h == 1) begin
        off = 16'($urandom);
        host_u.wr_reg(ADR_OFFSET, off);
      end
      @(posedge clk) smp <= 16'($urandom);
      // Random gain, buffer and coding bits beside the start bit.
      rv = 16'($urandom) & 16'h00f8 | 16'h0001;
      host_u.wr_reg(ADR_ADC_CTRL, rv);
      #1;
      chk(16'({bipol_o, nbuf_o, pbuf_o, gain}), 16'(rv[7:3]));
      wait_ready(n);
      chk(16'(n), 16'(FIRST_T));
      host_u.rd_reg(ADR_DATA, rv);
      chk(rv, exp_data(smp, off));
    end
    // DAC codes at both ends and a random one.
    for (int d = 0; d < 3; d++) begin
      dv = (d == 0) ? 10'h3ff : (d == 1) ? 10'h000 : 10'($urandom);
      host_u.wr_reg(ADR_DAC_A, 16'(dv));
      host_u.wr_reg(ADR_DAC_B, {6'h00, ~dv});
      #1;
      chk(16'(dac_a), 16'(dv));
      chk(16'(dac_b), {6'h00, ~dv});
    end
    host_u.rd_reg(5'h10, rv);
    chk(rv, 16'h0000);
    tally_and_finish();
  end
endmodule // power_mode_adc_control_test
